// ==== core/fmr_map.svh ====
// Purpose: register indices, field positions and latch layout of the fault gate block
// Assumes: included by its bare name from the design files
// Notes: byte address of a register is four times its index
`ifndef FMR_MAP_SVH
`define FMR_MAP_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define FMR_IDX_GATE_A 16'h0016
`define FMR_IDX_GATE_B 16'h0017
`define FMR_IDX_CLEAR_A 16'h0331
`define FMR_IDX_CLEAR_B 16'h0332
`define FMR_IDX_OVERVIEW 16'h052D

// ----------------------------------------------------------------
// reset values and writable bits
// ----------------------------------------------------------------
`define FMR_RST_BYTE 8'h00
`define FMR_GATE_A_USED 8'h9F
`define FMR_GATE_B_USED 8'h7F

// ----------------------------------------------------------------
// gate and clear register bit positions (same layout in both pairs)
// ----------------------------------------------------------------
`define FMR_A_PROT 7
`define FMR_A_UV 4
`define FMR_A_OV 3
`define FMR_A_COMP 2
`define FMR_A_SYS 1
`define FMR_A_PWR 0
`define FMR_B_OTP_CRC 6
`define FMR_B_OTP_ECC 5
`define FMR_B_FLINK 4
`define FMR_B_FTONE 3
`define FMR_B_HBEAT 2
`define FMR_B_DAISY 1
`define FMR_B_HOST 0

// ----------------------------------------------------------------
// overview bit positions
// ----------------------------------------------------------------
`define FMR_S_PROT 7
`define FMR_S_COMP 6
`define FMR_S_OTP 5
`define FMR_S_LINK 4
`define FMR_S_RSVD 3
`define FMR_S_VOLT 2
`define FMR_S_SYS 1
`define FMR_S_PWR 0

// ----------------------------------------------------------------
// bit positions inside the otp and third link flag bytes
// ----------------------------------------------------------------
`define FMR_OTP_CUSTOMER_CHECKSUM_ERROR 7
`define FMR_OTP_FACTORY_CHECKSUM_ERROR 6
`define FMR_OTP_SINGLE 1
`define FMR_OTP_DOUBLE 0
`define FMR_OTP_CRC_MASK 8'hC0
`define FMR_L3_FLINK 3
`define FMR_L3_FTONE 2
`define FMR_L3_HEARTBEAT_TOO_FAST 1
`define FMR_L3_HB_MISS 0

// ----------------------------------------------------------------
// layout of the flat latched flag vector: low bit and width per group
// ----------------------------------------------------------------
`define FMR_PROT_LO 0
`define FMR_PROT_W 16
`define FMR_UV_LO 16
`define FMR_UV_W 16
`define FMR_OV_LO 32
`define FMR_OV_W 16
`define FMR_COMP_LO 48
`define FMR_COMP_W 64
`define FMR_SYS_LO 112
`define FMR_SYS_W 8
`define FMR_PWR_LO 120
`define FMR_PWR_W 24
`define FMR_OTP_LO 144
`define FMR_L1_LO 152
`define FMR_L2_LO 160
`define FMR_L3_LO 168
`define FMR_DBG_U_LO 176
`define FMR_DBG_U_W 8
`define FMR_DBG_L_LO 184
`define FMR_DBG_L_W 16
`define FMR_BYTE_W 8
`define FMR_FLAG_W 200

`endif

// ==== core/fmr_pkg.sv ====
// Purpose: shared types of the fault gate block
// Assumes: layout numbers live in fmr_map.svh
// Notes: no constants here, only types
package fmr_pkg;
	typedef logic [7:0] fmr_byte_t; // one register byte
	typedef logic [31:0] fmr_word_t; // apb data word
	typedef logic [15:0] fmr_addr_t; // apb byte address
endpackage

// ==== core/fmr_latch_if.sv ====
// Purpose: carrier between the gate logic and the latched flag bank
// Assumes: one clock, driven by the top module
// Notes: set and clear are one-cycle strobes
`timescale 1ns/1ps
interface fmr_latch_if #(parameter int W = 200);
	logic [W-1:0] set; // fault events to latch
	logic [W-1:0] clr; // clear strobes
	logic [W-1:0] q; // latched flags
	modport ctrl (output set, output clr, input q);
	modport bank (input set, input clr, output q);
endinterface

// ==== core/fmr_flag_bank.sv ====
// Purpose: latched fault flag storage with set over clear priority
// Assumes: synchronous active-low reset, clock enable freezes state
// Notes: flags are read straight from flops
`timescale 1ns/1ps
module fmr_flag_bank #(
	parameter int W = 200
) (
	input wire logic core_clk, // device clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic ce, // clock enable
	fmr_latch_if.bank lb // set, clear and flag vectors
);
	// ----------------------------------------------------------------
	// flag storage
	// ----------------------------------------------------------------
	// a new event in the clear cycle survives, so a clear never drops a fault; events while ce is low are not latched
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			lb.q <= '0;
		else if (ce)
			lb.q <= (lb.q & ~lb.clr) | lb.set;
	end
endmodule

// ==== core/fmr_fault_gate.sv ====
// Purpose: fault gating, group clearing and overview for the alarm pin
// Assumes: apb slave, zero wait states, inputs synchronous to core_clk
// Notes: group flags are latched here from one-cycle event inputs
`timescale 1ns/1ps
`include "fmr_map.svh"
module fmr_fault_gate (
	input wire logic core_clk, // device clock, 100 MHz
	input wire logic rst_n, // synchronous reset, active low
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction, high for write
	input wire fmr_pkg::fmr_addr_t paddr, // apb byte address
	input wire fmr_pkg::fmr_word_t pwdata, // apb write data
	output fmr_pkg::fmr_word_t prdata, // apb read data, registered
	output logic pready, // apb ready
	output logic pslverr, // apb error for unmapped or read-only write
	input wire logic [`FMR_FLAG_W-1:0] fault_set, // one-cycle fault events
	output logic [`FMR_FLAG_W-1:0] fault_flags, // latched fault flags
	output logic alarm_out_n // fault alarm pin, active low
);
	// ----------------------------------------------------------------
	// state and wiring
	// ----------------------------------------------------------------
	fmr_pkg::fmr_byte_t gate_a_reg; // first gate register
	fmr_pkg::fmr_byte_t gate_b_reg; // second gate register
	fmr_pkg::fmr_byte_t overview_reg; // gated group overview
	fmr_pkg::fmr_byte_t overview_next; // overview computed from flags
	fmr_pkg::fmr_word_t prdata_reg; // read data captured in setup
	logic alarm_reg; // alarm pin flop, high means idle
	fmr_pkg::fmr_byte_t clear_a; // first clear strobe byte
	fmr_pkg::fmr_byte_t clear_b; // second clear strobe byte
	logic [`FMR_FLAG_W-1:0] q; // latched flags
	logic [`FMR_FLAG_W-1:0] clr_vec; // clear vector for the bank
	logic setup_ph; // apb setup phase
	logic access_ph; // apb access phase
	logic hit_ga; // first gate register addressed
	logic hit_gb; // second gate register addressed
	logic hit_ca; // first clear register addressed
	logic hit_cb; // second clear register addressed
	logic hit_ov; // overview addressed
	logic mapped; // any register addressed
	logic wr_ok; // accepted write this cycle
	fmr_pkg::fmr_byte_t otp_b; // otp flag byte
	fmr_pkg::fmr_byte_t l3_b; // third link flag byte

	fmr_latch_if #(.W(`FMR_FLAG_W)) lb ();

	fmr_flag_bank #(.W(`FMR_FLAG_W)) u_bank (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ce(ce),
		.lb(lb)
	);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// word address match: byte address is the index shifted by two
	function automatic logic reg_hit(input fmr_pkg::fmr_addr_t a, input logic [15:0] idx);
		return a == {idx[13:0], 2'b00};
	endfunction

	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	assign hit_ga = reg_hit(paddr, `FMR_IDX_GATE_A);
	assign hit_gb = reg_hit(paddr, `FMR_IDX_GATE_B);
	assign hit_ca = reg_hit(paddr, `FMR_IDX_CLEAR_A);
	assign hit_cb = reg_hit(paddr, `FMR_IDX_CLEAR_B);
	assign hit_ov = reg_hit(paddr, `FMR_IDX_OVERVIEW);
	assign mapped = hit_ga | hit_gb | hit_ca | hit_cb | hit_ov;
	// a write to the read-only overview is refused and stores nothing
	assign wr_ok = ce & access_ph & pwrite & mapped & ~hit_ov;
	// ready drops with the clock enable so the master waits out a freeze
	assign pready = ce;
	// holes in the map are refused with an error rather than aliased onto a register
	assign pslverr = access_ph & (~mapped | (pwrite & hit_ov));
	assign prdata = prdata_reg;

	// ----------------------------------------------------------------
	// gate registers
	// ----------------------------------------------------------------
	// reserved and spare bits are never stored, so they read as zero
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			gate_a_reg <= `FMR_RST_BYTE;
			gate_b_reg <= `FMR_RST_BYTE;
		end
		else if (wr_ok)
		begin
			if (hit_ga)
				gate_a_reg <= pwdata[7:0] & `FMR_GATE_A_USED;
			if (hit_gb)
				gate_b_reg <= pwdata[7:0] & `FMR_GATE_B_USED;
		end
	end

	// ----------------------------------------------------------------
	// clear strobes
	// ----------------------------------------------------------------
	// clear bits hold no state: they act only in the write cycle
	// only bits 7:0 of the word carry register data, the rest is ignored
	assign clear_a = (wr_ok & hit_ca) ? pwdata[7:0] : `FMR_RST_BYTE;
	assign clear_b = (wr_ok & hit_cb) ? pwdata[7:0] : `FMR_RST_BYTE;

	// build the per-bit clear vector from the strobe bytes
	always_comb
	begin
		clr_vec = '0;
		clr_vec[`FMR_PROT_LO +: `FMR_PROT_W] = {`FMR_PROT_W{clear_a[`FMR_A_PROT]}};
		clr_vec[`FMR_UV_LO +: `FMR_UV_W] = {`FMR_UV_W{clear_a[`FMR_A_UV]}};
		clr_vec[`FMR_OV_LO +: `FMR_OV_W] = {`FMR_OV_W{clear_a[`FMR_A_OV]}};
		clr_vec[`FMR_COMP_LO +: `FMR_COMP_W] = {`FMR_COMP_W{clear_a[`FMR_A_COMP]}};
		clr_vec[`FMR_SYS_LO +: `FMR_SYS_W] = {`FMR_SYS_W{clear_a[`FMR_A_SYS]}};
		clr_vec[`FMR_PWR_LO +: `FMR_PWR_W] = {`FMR_PWR_W{clear_a[`FMR_A_PWR]}};
		// otp: each strobe touches only its own pair of bits
		clr_vec[`FMR_OTP_LO + `FMR_OTP_CUSTOMER_CHECKSUM_ERROR] = clear_b[`FMR_B_OTP_CRC];
		clr_vec[`FMR_OTP_LO + `FMR_OTP_FACTORY_CHECKSUM_ERROR] = clear_b[`FMR_B_OTP_CRC];
		clr_vec[`FMR_OTP_LO + `FMR_OTP_SINGLE] = clear_b[`FMR_B_OTP_ECC];
		clr_vec[`FMR_OTP_LO + `FMR_OTP_DOUBLE] = clear_b[`FMR_B_OTP_ECC];
		clr_vec[`FMR_L3_LO + `FMR_L3_FLINK] = clear_b[`FMR_B_FLINK];
		clr_vec[`FMR_L3_LO + `FMR_L3_FTONE] = clear_b[`FMR_B_FTONE];
		clr_vec[`FMR_L3_LO + `FMR_L3_HEARTBEAT_TOO_FAST] = clear_b[`FMR_B_HBEAT];
		clr_vec[`FMR_L3_LO + `FMR_L3_HB_MISS] = clear_b[`FMR_B_HBEAT];
		// link groups take their debug bytes with them
		clr_vec[`FMR_L2_LO +: `FMR_BYTE_W] = {`FMR_BYTE_W{clear_b[`FMR_B_DAISY]}};
		clr_vec[`FMR_DBG_L_LO +: `FMR_DBG_L_W] = {`FMR_DBG_L_W{clear_b[`FMR_B_DAISY]}};
		clr_vec[`FMR_L1_LO +: `FMR_BYTE_W] = {`FMR_BYTE_W{clear_b[`FMR_B_HOST]}};
		clr_vec[`FMR_DBG_U_LO +: `FMR_DBG_U_W] = {`FMR_DBG_U_W{clear_b[`FMR_B_HOST]}};
	end

	// events go to the bank unfiltered: gates act only downstream
	assign lb.set = fault_set;
	assign lb.clr = clr_vec;
	assign q = lb.q;
	assign fault_flags = q;
	assign otp_b = q[`FMR_OTP_LO +: `FMR_BYTE_W];
	assign l3_b = q[`FMR_L3_LO +: `FMR_BYTE_W];

	// ----------------------------------------------------------------
	// gated overview
	// ----------------------------------------------------------------
	// a gate bit of 1 suppresses its group, 0 lets it through
	// both otp gates feed one overview bit, as the five link sources do
	always_comb
	begin
		overview_next = `FMR_RST_BYTE;
		overview_next[`FMR_S_PROT] = ~gate_a_reg[`FMR_A_PROT]
			& (|q[`FMR_PROT_LO +: `FMR_PROT_W]);
		overview_next[`FMR_S_COMP] = ~gate_a_reg[`FMR_A_COMP]
			& (|q[`FMR_COMP_LO +: `FMR_COMP_W]);
		overview_next[`FMR_S_OTP] =
			(~gate_b_reg[`FMR_B_OTP_CRC] & (|(otp_b & `FMR_OTP_CRC_MASK)))
			| (~gate_b_reg[`FMR_B_OTP_ECC] & (|(otp_b & ~`FMR_OTP_CRC_MASK)));
		overview_next[`FMR_S_LINK] =
			(~gate_b_reg[`FMR_B_HOST] & (|q[`FMR_L1_LO +: `FMR_BYTE_W]))
			| (~gate_b_reg[`FMR_B_DAISY] & (|q[`FMR_L2_LO +: `FMR_BYTE_W]))
			| (~gate_b_reg[`FMR_B_FLINK] & l3_b[`FMR_L3_FLINK])
			| (~gate_b_reg[`FMR_B_FTONE] & l3_b[`FMR_L3_FTONE])
			| (~gate_b_reg[`FMR_B_HBEAT]
				& (l3_b[`FMR_L3_HEARTBEAT_TOO_FAST] | l3_b[`FMR_L3_HB_MISS]));
		overview_next[`FMR_S_VOLT] =
			(~gate_a_reg[`FMR_A_OV] & (|q[`FMR_OV_LO +: `FMR_OV_W]))
			| (~gate_a_reg[`FMR_A_UV] & (|q[`FMR_UV_LO +: `FMR_UV_W]));
		overview_next[`FMR_S_SYS] = ~gate_a_reg[`FMR_A_SYS]
			& (|q[`FMR_SYS_LO +: `FMR_SYS_W]);
		overview_next[`FMR_S_PWR] = ~gate_a_reg[`FMR_A_PWR]
			& (|q[`FMR_PWR_LO +: `FMR_PWR_W]);
	end

	// overview and pin share one flop stage so software and pin agree
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			overview_reg <= `FMR_RST_BYTE;
			alarm_reg <= 1'b1;
		end
		else if (ce)
		begin
			overview_reg <= overview_next;
			alarm_reg <= ~(|overview_next);
		end
	end

	assign alarm_out_n = alarm_reg;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// captured in setup so prdata comes from a flop with no wait state;
	// limitation: the overview read is the value one cycle before access
	// clear registers are write strobes, so there is nothing to read back
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			prdata_reg <= '0;
		else if (ce && setup_ph && !pwrite)
		begin
			if (hit_ga)
				prdata_reg <= {24'h00_0000, gate_a_reg};
			else if (hit_gb)
				prdata_reg <= {24'h00_0000, gate_b_reg};
			else if (hit_ov)
				prdata_reg <= {24'h00_0000, overview_reg};
			else
				prdata_reg <= '0; // clear registers and holes read zero
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	// all checks run on the device clock and sleep while reset is low
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------------------------------
	// gate checks
	// ----------------------------------------------------------------
	prot_gate_open_a: assert property (ce && !gate_a_reg[`FMR_A_PROT]
		&& (|q[`FMR_PROT_LO +: `FMR_PROT_W]) |=> overview_reg[`FMR_S_PROT])
		else $error("protector fault not shown");
	uv_gate_shut_a: assert property (ce && gate_a_reg[`FMR_A_UV]
		&& gate_a_reg[`FMR_A_OV] |=> !overview_reg[`FMR_S_VOLT])
		else $error("voltage bit set while both gated");
	uv_gate_open_a: assert property (ce && !gate_a_reg[`FMR_A_UV]
		&& (|q[`FMR_UV_LO +: `FMR_UV_W]) |=> overview_reg[`FMR_S_VOLT])
		else $error("undervoltage fault not shown");
	ov_gate_open_a: assert property (ce && !gate_a_reg[`FMR_A_OV]
		&& (|q[`FMR_OV_LO +: `FMR_OV_W]) |=> overview_reg[`FMR_S_VOLT] ##0 !alarm_out_n)
		else $error("overvoltage fault not raised");
	comp_gate_shut_a: assert property (ce && gate_a_reg[`FMR_A_COMP]
		|=> !overview_reg[`FMR_S_COMP])
		else $error("comparison bit set while gated");
	sys_gate_shut_a: assert property (ce && gate_a_reg[`FMR_A_SYS]
		|=> !overview_reg[`FMR_S_SYS])
		else $error("system bit set while gated");
	pwr_gate_open_a: assert property (ce && !gate_a_reg[`FMR_A_PWR]
		&& (|q[`FMR_PWR_LO +: `FMR_PWR_W]) |=> overview_reg[`FMR_S_PWR])
		else $error("power fault not shown");
	otp_crc_open_a: assert property (ce && !gate_b_reg[`FMR_B_OTP_CRC]
		&& (|(otp_b & `FMR_OTP_CRC_MASK)) |=> overview_reg[`FMR_S_OTP])
		else $error("otp checksum fault not shown");
	otp_gate_shut_a: assert property (ce && gate_b_reg[`FMR_B_OTP_CRC]
		&& gate_b_reg[`FMR_B_OTP_ECC] |=> !overview_reg[`FMR_S_OTP])
		else $error("otp bit set while gated");
	link_hb_open_a: assert property (ce && !gate_b_reg[`FMR_B_HBEAT]
		&& l3_b[`FMR_L3_HB_MISS] |=> overview_reg[`FMR_S_LINK])
		else $error("heartbeat fault not shown");
	tone_gate_open_a: assert property (ce && !gate_b_reg[`FMR_B_FTONE]
		&& l3_b[`FMR_L3_FTONE] |=> overview_reg[`FMR_S_LINK])
		else $error("fault tone not shown");
	host_gate_open_a: assert property (ce && !gate_b_reg[`FMR_B_HOST]
		&& (|q[`FMR_L1_LO +: `FMR_BYTE_W]) |=> overview_reg[`FMR_S_LINK])
		else $error("host link fault not shown");
	daisy_gate_open_a: assert property (ce && !gate_b_reg[`FMR_B_DAISY]
		&& (|q[`FMR_L2_LO +: `FMR_BYTE_W]) |=> overview_reg[`FMR_S_LINK])
		else $error("daisy link fault not shown");
	link_gate_shut_a: assert property (ce && gate_b_reg[`FMR_B_HOST]
		&& gate_b_reg[`FMR_B_DAISY] && gate_b_reg[`FMR_B_FLINK]
		&& gate_b_reg[`FMR_B_FTONE] && gate_b_reg[`FMR_B_HBEAT]
		|=> !overview_reg[`FMR_S_LINK])
		else $error("link bit set while gated");

	// ----------------------------------------------------------------
	// clear checks
	// ----------------------------------------------------------------
	// each flag clear check excludes a new event in the same cycle, since set wins
	prot_clear_a: assert property (wr_ok && hit_ca && pwdata[`FMR_A_PROT]
		&& !(|fault_set[`FMR_PROT_LO +: `FMR_PROT_W])
		|=> q[`FMR_PROT_LO +: `FMR_PROT_W] == '0 ##1 !overview_reg[`FMR_S_PROT])
		else $error("protector clear failed");
	uv_clear_a: assert property (wr_ok && hit_ca && pwdata[`FMR_A_UV]
		&& !(|fault_set[`FMR_UV_LO +: `FMR_UV_W])
		|=> q[`FMR_UV_LO +: `FMR_UV_W] == '0)
		else $error("undervoltage clear failed");
	comp_clear_a: assert property (wr_ok && hit_ca && pwdata[`FMR_A_COMP]
		&& !(|fault_set[`FMR_COMP_LO +: `FMR_COMP_W])
		|=> q[`FMR_COMP_LO +: `FMR_COMP_W] == '0)
		else $error("comparison clear failed");
	sys_clear_a: assert property (wr_ok && hit_ca && pwdata[`FMR_A_SYS]
		&& !(|fault_set[`FMR_SYS_LO +: `FMR_SYS_W])
		|=> q[`FMR_SYS_LO +: `FMR_SYS_W] == '0)
		else $error("system clear failed");
	otp_ecc_only_a: assert property (wr_ok && hit_cb && pwdata[`FMR_B_OTP_ECC]
		&& !pwdata[`FMR_B_OTP_CRC] && !(|(fault_set[`FMR_OTP_LO +: `FMR_BYTE_W]
		& `FMR_OTP_CRC_MASK)) |=> (otp_b & `FMR_OTP_CRC_MASK)
		== ($past(otp_b) & `FMR_OTP_CRC_MASK))
		else $error("ecc clear touched checksum bits");
	tone_clear_a: assert property (wr_ok && hit_cb && pwdata[`FMR_B_FTONE]
		&& !fault_set[`FMR_L3_LO + `FMR_L3_FTONE] |=> !l3_b[`FMR_L3_FTONE])
		else $error("fault tone clear failed");
	daisy_clear_a: assert property (wr_ok && hit_cb && pwdata[`FMR_B_DAISY]
		&& !(|fault_set[`FMR_DBG_L_LO +: `FMR_DBG_L_W])
		|=> q[`FMR_DBG_L_LO +: `FMR_DBG_L_W] == '0)
		else $error("daisy debug clear failed");
	clear_reads_a: assert property (ce && setup_ph && !pwrite
		&& (hit_ca || hit_cb) |=> prdata == '0)
		else $error("clear register read nonzero");

	// ----------------------------------------------------------------
	// latch, pin and reserved bit checks
	// ----------------------------------------------------------------
	latch_always_a: assert property (ce |=> (q & $past(fault_set)) == $past(fault_set))
		else $error("fault event not latched");
	alarm_match_a: assert property (alarm_out_n == !(|overview_reg))
		else $error("alarm pin disagrees with overview");
	rsvd_zero_a: assert property (!overview_reg[`FMR_S_RSVD])
		else $error("reserved overview bit set");

	// ----------------------------------------------------------------
	// coverage
	// ----------------------------------------------------------------
	alarm_seen_c: cover property (alarm_out_n ##1 !alarm_out_n);
	alarm_clear_c: cover property (!alarm_out_n ##1 alarm_out_n);
	masked_fault_c: cover property (gate_a_reg[`FMR_A_PROT]
		&& (|q[`FMR_PROT_LO +: `FMR_PROT_W]) && alarm_out_n);
	set_vs_clear_c: cover property (wr_ok && hit_ca && pwdata[`FMR_A_PROT]
		&& fault_set[`FMR_PROT_LO]);
	ce_freeze_c: cover property (!ce && (|fault_set));
endmodule

// ==== tb/fmr_host_mon.sv ====
// Purpose: host side model that watches the alarm pin
// Assumes: pin sampled on the device clock, same reset as the device
// Notes: counts each new assertion so the bench can match alarms to the faults it raised
`timescale 1ns/1ps
module fmr_host_mon (
	input wire logic core_clk, // device clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic alarm_out_n, // alarm pin from the device, active low
	output logic [7:0] alarm_cnt // number of alarms seen since reset
);
	logic pin_reg; // pin level at the previous edge
	logic [7:0] cnt_reg; // running alarm count

	// ----------------------------------------------------------------
	// falling edge counter
	// ----------------------------------------------------------------
	// a pin that was high and is now low is one new alarm; a level that
	// simply stays low is not counted again, as a polling host would see it
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			pin_reg <= 1'b1;
			cnt_reg <= 8'h00;
		end
		else
		begin
			pin_reg <= alarm_out_n;
			if (pin_reg && !alarm_out_n)
				cnt_reg <= cnt_reg + 8'h01;
		end
	end
	assign alarm_cnt = cnt_reg;
endmodule

// ==== tb/fmr_fault_gate_tb.sv ====
// Purpose: self-checking bench of the fault gate block
// Assumes: zero wait state apb slave, clock enable high except in one freeze test
// Notes: one table row per gated source: masked, unmasked, then cleared
`timescale 1ns/1ps
`include "fmr_map.svh"
module fmr_fault_gate_tb;
	logic core_clk, rst_n, ce, psel, penable, pwrite, err; // clock, reset, apb, last error
	fmr_pkg::fmr_addr_t paddr, sel, clr; // apb address, row gate and clear addresses
	fmr_pkg::fmr_word_t pwdata, prdata, rd; // write data, read data, last read
	logic pready, pslverr, alarm_out_n; // answers and alarm pin
	logic [`FMR_FLAG_W-1:0] fault_set, fault_flags; // event pulses and latched flags
	logic [7:0] alarm_cnt; // alarms seen by the host model
	int num_errors, checked; // mismatch and compare counters
	localparam fmr_pkg::fmr_addr_t ga = `FMR_IDX_GATE_A << 2; // gate a byte address
	localparam fmr_pkg::fmr_addr_t gb = `FMR_IDX_GATE_B << 2; // gate b byte address
	localparam fmr_pkg::fmr_addr_t ca = `FMR_IDX_CLEAR_A << 2; // clear a byte address
	localparam fmr_pkg::fmr_addr_t cb = `FMR_IDX_CLEAR_B << 2; // clear b byte address
	localparam fmr_pkg::fmr_addr_t ov = `FMR_IDX_OVERVIEW << 2; // overview byte address
	fmr_pkg::fmr_addr_t regs[5] = '{ga, gb, ca, cb, ov}; // all mapped registers
	// flag, second flag of the same group, register b, gate/clear bit, overview bit
	int tbl[13][5] = '{
		'{3, 12, 0, 7, 7},
		'{20, 31, 0, 4, 2},
		'{40, 47, 0, 3, 2},
		'{50, 111, 0, 2, 6},
		'{112, 119, 0, 1, 1},
		'{120, 143, 0, 0, 0},
		'{151, 150, 1, 6, 5},
		'{144, 145, 1, 5, 5},
		'{171, 171, 1, 4, 4},
		'{170, 170, 1, 3, 4},
		'{169, 168, 1, 2, 4},
		'{162, 190, 1, 1, 4},
		'{156, 180, 1, 0, 4}
	};

	fmr_fault_gate uut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fault_set(fault_set), .fault_flags(fault_flags),
		.alarm_out_n(alarm_out_n));
	fmr_host_mon host (.core_clk(core_clk), .rst_n(rst_n), .alarm_out_n(alarm_out_n),
		.alarm_cnt(alarm_cnt));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic results();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// one apb transfer; starts at the next edge so two calls never collide
	task automatic apb(input logic wr, input fmr_pkg::fmr_addr_t a, input fmr_pkg::fmr_word_t d);
		int n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge core_clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 50)
		begin
			num_errors++;
			results();
		end
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge core_clk);
	endtask

	// one-cycle event on two flag positions
	task automatic pulse(input int i, input int j);
		@(posedge core_clk);
		fault_set[i] <= 1'b1;
		fault_set[j] <= 1'b1;
		@(posedge core_clk);
		fault_set <= '0;
	endtask

	task automatic chk_word(input fmr_pkg::fmr_word_t got, input fmr_pkg::fmr_word_t exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t: word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t: bit %b expected %b", $time, got, exp);
		end
	endtask

	// ----------------------------------------------------------------
	// clock and main sequence
	// ----------------------------------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial
	begin
		{rst_n, psel, penable, pwrite, err} = '0;
		ce = 1'b1;
		paddr = '0;
		pwdata = '0;
		fault_set = '0;
		num_errors = 0;
		checked = 0;
		tick(3);
		rst_n <= 1'b1;
		foreach (regs[k])
		begin
			apb(1'b0, regs[k], 32'h0000_0000);
			chk_word(rd, 32'h0000_0000);
		end
		apb(1'b1, ga, 32'h0000_00FF);
		apb(1'b0, ga, 32'h0000_0000);
		chk_word(rd, 32'h0000_009F);
		apb(1'b1, gb, 32'h0000_00FF);
		apb(1'b0, gb, 32'h0000_0000);
		chk_word(rd, 32'h0000_007F);
		apb(1'b1, ov, 32'h0000_00FF);
		chk_bit(err, 1'b1);
		apb(1'b0, 16'h0100, 32'h0000_0000);
		chk_bit(err, 1'b1);
		chk_word(rd, 32'h0000_0000);
		$display("test registers done");
		for (int r = 0; r < 13; r++)
		begin
			sel = tbl[r][2] ? gb : ga;
			clr = tbl[r][2] ? cb : ca;
			apb(1'b1, sel, 32'h0000_00FF);
			pulse(tbl[r][0], tbl[r][1]);
			tick(2);
			chk_bit(fault_flags[tbl[r][0]], 1'b1);
			chk_bit(fault_flags[tbl[r][1]], 1'b1);
			chk_bit(alarm_out_n, 1'b1);
			apb(1'b0, ov, 32'h0000_0000);
			chk_word(rd, 32'h0000_0000);
			apb(1'b1, sel, 32'h0000_00FF ^ (32'h0000_0001 << tbl[r][3]));
			tick(2);
			chk_bit(alarm_out_n, 1'b0);
			apb(1'b0, ov, 32'h0000_0000);
			chk_word(rd, 32'h0000_0001 << tbl[r][4]);
			apb(1'b1, clr, 32'h0000_0001 << tbl[r][3]);
			tick(2);
			chk_bit(fault_flags[tbl[r][0]], 1'b0);
			chk_bit(fault_flags[tbl[r][1]], 1'b0);
			chk_bit(alarm_out_n, 1'b1);
			apb(1'b0, clr, 32'h0000_0000);
			chk_word(rd, 32'h0000_0000);
		end
		$display("test groups done");
		// both otp kinds raised; the ecc clear must leave the checksum kind alone
		apb(1'b1, gb, 32'h0000_0000);
		pulse(151, 145);
		apb(1'b1, cb, 32'h0000_0020);
		tick(2);
		chk_bit(fault_flags[145], 1'b0);
		chk_bit(fault_flags[151], 1'b1);
		chk_bit(alarm_out_n, 1'b0);
		apb(1'b1, cb, 32'h0000_0040);
		tick(2);
		chk_bit(fault_flags[151], 1'b0);
		chk_bit(alarm_out_n, 1'b1);
		chk_word({24'h00_0000, alarm_cnt}, 32'h0000_000E);
		$display("test otp done");
		// frozen enable: ready drops and an event in the freeze is lost
		ce <= 1'b0;
		pulse(3, 12);
		chk_bit(pready, 1'b0);
		chk_bit(fault_flags[3], 1'b0);
		ce <= 1'b1;
		tick(1);
		chk_bit(pready, 1'b1);
		$display("test enable done");
		// reset in mid-run with a live alarm returns everything to idle
		apb(1'b1, ga, 32'h0000_0000);
		pulse(3, 12);
		tick(2);
		chk_bit(alarm_out_n, 1'b0);
		rst_n <= 1'b0;
		tick(2);
		rst_n <= 1'b1;
		tick(1);
		chk_bit(alarm_out_n, 1'b1);
		chk_bit(fault_flags[12], 1'b0);
		chk_word({24'h00_0000, alarm_cnt}, 32'h0000_0000);
		apb(1'b0, ga, 32'h0000_0000);
		chk_word(rd, 32'h0000_0000);
		$display("test reset done");
		results();
	end
endmodule
